// ---- rtl/srlu_top.sv ----
// Set-reset latch unit: register port, input selection, divided clock
// source, firmware pulses, the latch and its two pin routes.
// Assumes comparator and interrupt inputs are asynchronous to core_clk and
// that pin direction is handled by the port logic outside this block.
`timescale 1ns/10ps

// Overview of operation
// - Stored state holds indefinitely; only set and reset inputs change it.
// - Every set and reset input is active when high.
// - Comparators, interrupt pin or divided clock may set or reset the latch.
// - Writing pulse-set bit sets latch; writing pulse-reset bit resets it.
// - Simultaneous set and reset leaves the latch reset.
// - Pulse bits clear themselves; one write completes the action.
// - True and inverted outputs each route to own pin by own enable.
// - No reset initialises the stored latch state.
// - Three-bit field divides peripheral clock by 4 up to 512.
// - Latch enable bit turns module on when one; resets to zero.
// - Per-source enables gate each source onto set and reset separately.
// - Enabled clock source pulses set or reset at divided clock rate.
module srlu_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [srlu_pkg::SRLU_ADDR_W-1:0] regAddr,
	input wire logic [srlu_pkg::SRLU_DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [srlu_pkg::SRLU_DATA_W-1:0] regRdata,
	// Latch sources
	input wire logic comparator1Output,
	input wire logic comparator2Output,
	input wire logic externalInterruptPin,
	// Pin routes
	output logic trueOutPin,
	output logic trueOutPinOe,
	output logic invertedOutPin,
	output logic invertedOutPinOe
);
	import srlu_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] latchControlReg;
	logic [7:0] next_latchControlReg;
	logic [7:0] sourceEnableReg;
	logic [7:0] next_sourceEnableReg;
	logic pulseSet;
	logic next_pulseSet;
	logic pulseReset;
	logic next_pulseReset;
	logic [7:0] next_regRdata;
	logic latchModuleEnable;
	logic [SRLU_DIV_SEL_W-1:0] latchClockDivider;
	logic ctrlWrite;

	assign latchModuleEnable = latchControlReg[SRLU_CTRL_ENABLE];
	assign latchClockDivider = latchControlReg[SRLU_CTRL_DIV_HI:SRLU_CTRL_DIV_LO];
	assign ctrlWrite = regWrite && (regAddr == SRLU_OFS_CTRL);

	// Latch state, declared here for the status read
	logic latchQ;
	logic next_latchQ;

	always_comb begin
		next_latchControlReg = latchControlReg;
		next_sourceEnableReg = sourceEnableReg;
		if (ctrlWrite) begin
			// Pulse bits are never stored, so they read back zero
			next_latchControlReg = regWdata;
			next_latchControlReg[SRLU_CTRL_PSET] = 1'b0;
			next_latchControlReg[SRLU_CTRL_PRST] = 1'b0;
		end
		if (regWrite && (regAddr == SRLU_OFS_SRC)) begin
			next_sourceEnableReg = regWdata;
		end
		next_pulseSet = ctrlWrite && regWdata[SRLU_CTRL_PSET];
		next_pulseReset = ctrlWrite && regWdata[SRLU_CTRL_PRST];
		next_regRdata = 8'h00;
		if (regRead) begin
			case (regAddr)
				SRLU_OFS_CTRL: begin
					next_regRdata = latchControlReg;
				end
				SRLU_OFS_SRC: begin
					next_regRdata = sourceEnableReg;
				end
				SRLU_OFS_STAT: begin
					next_regRdata[SRLU_STAT_Q] = latchQ;
					next_regRdata[SRLU_STAT_QN] = ~latchQ;
				end
				default: begin
					next_regRdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			latchControlReg <= SRLU_CTRL_RESET;
			sourceEnableReg <= SRLU_SRC_RESET;
			pulseSet <= 1'b0;
			pulseReset <= 1'b0;
			regRdata <= 8'h00;
		end else begin
			latchControlReg <= next_latchControlReg;
			sourceEnableReg <= next_sourceEnableReg;
			pulseSet <= next_pulseSet;
			pulseReset <= next_pulseReset;
			regRdata <= next_regRdata;
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [SRLU_NUM_ASYNC-1:0] asyncIn;
	logic [SRLU_NUM_ASYNC-1:0] syncMeta;
	logic [SRLU_NUM_ASYNC-1:0] syncIn;

	assign asyncIn[SRLU_IDX_PIN] = externalInterruptPin;
	assign asyncIn[SRLU_IDX_C2] = comparator2Output;
	assign asyncIn[SRLU_IDX_C1] = comparator1Output;

	genvar gi;
	generate
		for (gi = 0; gi < SRLU_NUM_ASYNC; gi++) begin : g_sync
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					syncMeta[gi] <= 1'b0;
					syncIn[gi] <= 1'b0;
				end else begin
					syncMeta[gi] <= asyncIn[gi];
					syncIn[gi] <= syncMeta[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Divided latch clock
	// ----------------------------------------------------------------
	logic latchClockTick;

	// Changing the divider while running can shorten one period
	srlu_clk_div #(
		.CNT_W(SRLU_DIV_CNT_W)
	) u_clk_div (
		.core_clk(core_clk),
		.reset(reset),
		.run(latchModuleEnable),
		.divSel(latchClockDivider),
		.tick(latchClockTick)
	);

	// ----------------------------------------------------------------
	// Set and reset inputs
	// ----------------------------------------------------------------
	logic setInput;
	logic resetInput;

	always_comb begin
		setInput = (sourceEnableReg[SRLU_SRC_SET_PIN] && syncIn[SRLU_IDX_PIN])
			|| (sourceEnableReg[SRLU_SRC_SET_CLK] && latchClockTick)
			|| (sourceEnableReg[SRLU_SRC_SET_C2] && syncIn[SRLU_IDX_C2])
			|| (sourceEnableReg[SRLU_SRC_SET_C1] && syncIn[SRLU_IDX_C1])
			|| pulseSet;
		resetInput = (sourceEnableReg[SRLU_SRC_RST_PIN] && syncIn[SRLU_IDX_PIN])
			|| (sourceEnableReg[SRLU_SRC_RST_CLK] && latchClockTick)
			|| (sourceEnableReg[SRLU_SRC_RST_C2] && syncIn[SRLU_IDX_C2])
			|| (sourceEnableReg[SRLU_SRC_RST_C1] && syncIn[SRLU_IDX_C1])
			|| pulseReset;
		// A disabled module ignores every source
		setInput = setInput && latchModuleEnable;
		resetInput = resetInput && latchModuleEnable;
	end

	// ----------------------------------------------------------------
	// Latch
	// ----------------------------------------------------------------
	always_comb begin
		next_latchQ = latchQ;
		if (resetInput == 1'b1) begin
			next_latchQ = 1'b0;
		end else if (setInput == 1'b1) begin
			next_latchQ = 1'b1;
		end
	end

	// Deliberately no reset: state is unknown until firmware sets it
	always_ff @(posedge core_clk) begin
		latchQ <= next_latchQ;
	end

	// ----------------------------------------------------------------
	// Pin routes
	// ----------------------------------------------------------------
	logic next_trueOutPin;
	logic next_trueOutPinOe;
	logic next_invertedOutPin;
	logic next_invertedOutPinOe;

	always_comb begin
		next_trueOutPinOe = latchModuleEnable && latchControlReg[SRLU_CTRL_TRUE_OE];
		next_invertedOutPinOe = latchModuleEnable && latchControlReg[SRLU_CTRL_INV_OE];
		// Gated so an uninitialised latch never reaches a disabled pin
		next_trueOutPin = next_trueOutPinOe && latchQ;
		next_invertedOutPin = next_invertedOutPinOe && !latchQ;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			trueOutPin <= 1'b0;
			trueOutPinOe <= 1'b0;
			invertedOutPin <= 1'b0;
			invertedOutPinOe <= 1'b0;
		end else begin
			trueOutPin <= next_trueOutPin;
			trueOutPinOe <= next_trueOutPinOe;
			invertedOutPin <= next_invertedOutPin;
			invertedOutPinOe <= next_invertedOutPinOe;
		end
	end

endmodule

// ---- rtl/srlu_pkg.sv ----
// Constants for the set-reset latch unit: register map, field positions,
// reset values and divider figures.
// Assumes an 8-bit register port with one register per address.
package srlu_pkg;

	localparam int SRLU_ADDR_W = 2;
	localparam int SRLU_DATA_W = 8;

	// Register offsets
	localparam logic [1:0] SRLU_OFS_CTRL = 2'h0;
	localparam logic [1:0] SRLU_OFS_SRC = 2'h1;
	localparam logic [1:0] SRLU_OFS_STAT = 2'h2;

	// Control register fields
	localparam int SRLU_CTRL_ENABLE = 7;
	localparam int SRLU_CTRL_DIV_HI = 6;
	localparam int SRLU_CTRL_DIV_LO = 4;
	localparam int SRLU_CTRL_TRUE_OE = 3;
	localparam int SRLU_CTRL_INV_OE = 2;
	localparam int SRLU_CTRL_PSET = 1;
	localparam int SRLU_CTRL_PRST = 0;

	// Source enable register fields
	localparam int SRLU_SRC_SET_PIN = 7;
	localparam int SRLU_SRC_SET_CLK = 6;
	localparam int SRLU_SRC_SET_C2 = 5;
	localparam int SRLU_SRC_SET_C1 = 4;
	localparam int SRLU_SRC_RST_PIN = 3;
	localparam int SRLU_SRC_RST_CLK = 2;
	localparam int SRLU_SRC_RST_C2 = 1;
	localparam int SRLU_SRC_RST_C1 = 0;

	// Status register fields
	localparam int SRLU_STAT_Q = 0;
	localparam int SRLU_STAT_QN = 1;

	localparam logic [7:0] SRLU_CTRL_RESET = 8'h00;
	localparam logic [7:0] SRLU_SRC_RESET = 8'h00;

	// Divider: code 0 divides by 4, each step doubles, up to 512
	localparam int SRLU_DIV_SEL_W = 3;
	localparam int SRLU_DIV_BASE_LOG2 = 2;
	localparam int SRLU_DIV_CNT_W = 9;

	// Number of synchronised asynchronous inputs: pin, comparator 2, comparator 1
	localparam int SRLU_NUM_ASYNC = 3;
	localparam int SRLU_IDX_PIN = 2;
	localparam int SRLU_IDX_C2 = 1;
	localparam int SRLU_IDX_C1 = 0;

endpackage

// ---- rtl/srlu_clk_div.sv ----
// Divided latch clock: a one-cycle tick every 4 << divSel core cycles.
// Assumes core_clk is the peripheral cycle clock.
`timescale 1ns/10ps
module srlu_clk_div #(
	parameter int CNT_W = srlu_pkg::SRLU_DIV_CNT_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Control
	input wire logic run,
	input wire logic [srlu_pkg::SRLU_DIV_SEL_W-1:0] divSel,
	// Tick
	output logic tick
);
	import srlu_pkg::*;

	generate
		if (CNT_W < SRLU_DIV_CNT_W) begin : g_chk
			$error("srlu_clk_div: CNT_W too small for divide by 512");
		end
	endgenerate

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] limit;
	logic next_tick;

	always_comb begin
		limit = CNT_W'((CNT_W'(1) << (CNT_W'(divSel) + CNT_W'(SRLU_DIV_BASE_LOG2))) - CNT_W'(1));
		next_tick = 1'b0;
		if (!run) begin
			next_count = '0;
		end else if (count >= limit) begin
			// Also catches a divider code lowered mid-period
			next_count = '0;
			next_tick = 1'b1;
		end else begin
			next_count = CNT_W'(count + CNT_W'(1));
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			count <= '0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

endmodule

// ---- verif/srlu_src_model.sv ----
// Far-side model: the two comparator outputs and the interrupt pin.
// Assumes the bench asks for levels; they change just after a clock edge.
`timescale 1ns/10ps
module srlu_src_model (
	// Clock
	input wire logic core_clk,
	// Requested levels: pin, comparator 2, comparator 1
	input wire logic [2:0] want,
	// Source lines
	output logic comp1,
	output logic comp2,
	output logic pin
);
	// Quiet low before the first edge so the design sees no unknown
	initial {pin, comp2, comp1} = 3'h0;
	// Levels are active high and held until asked to change
	always @(posedge core_clk) begin
		{pin, comp2, comp1} <= want;
	end
endmodule

// ---- verif/srlu_top_properties.sv ----
// Port checker for the latch unit: pulse bits, pin routes, status pairing.
// Assumes it is bound to srlu_top and sees its ports only.
`timescale 1ns/10ps
module srlu_top_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [srlu_pkg::SRLU_ADDR_W-1:0] regAddr,
	input wire logic [srlu_pkg::SRLU_DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [srlu_pkg::SRLU_DATA_W-1:0] regRdata,
	// Pin routes
	input wire logic trueOutPin,
	input wire logic trueOutPinOe,
	input wire logic invertedOutPin,
	input wire logic invertedOutPinOe
);
	import srlu_pkg::*;
	logic [7:0] srcMirror;
	logic [7:0] next_srcMirror;
	// ----
	// Source enables, mirrored so pulse checks only fire when no source can interfere
	// ----
	always_comb begin
		next_srcMirror = srcMirror;
		if (regWrite && regAddr == SRLU_OFS_SRC) next_srcMirror = regWdata;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) srcMirror <= SRLU_SRC_RESET;
		else srcMirror <= next_srcMirror;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_pulse(logic [1:0] b);
		regWrite && regAddr == SRLU_OFS_CTRL && regWdata[7] && regWdata[1:0] == b && srcMirror == 8'h00;
	endsequence
	sequence s_stat_rd;
		!regWrite ##1 (regRead && regAddr == SRLU_OFS_STAT);
	endsequence
	a_pulse_bits_zero: assert property (regRead && regAddr == SRLU_OFS_CTRL |=> regRdata[1:0] == 2'h0)
		else $error("pulse bit read back set");
	a_true_oe_follow: assert property (regWrite && regAddr == SRLU_OFS_CTRL |-> ##2
		trueOutPinOe == ($past(regWdata[7], 2) && $past(regWdata[3], 2))) else $error("true pin enable wrong");
	a_inv_oe_follow: assert property (regWrite && regAddr == SRLU_OFS_CTRL |-> ##2
		invertedOutPinOe == ($past(regWdata[7], 2) && $past(regWdata[2], 2))) else $error("inverted enable wrong");
	a_pins_gated: assert property ((!trueOutPin || trueOutPinOe) && (!invertedOutPin || invertedOutPinOe))
		else $error("pin driven while not routed");
	a_pins_opposite: assert property (trueOutPinOe && invertedOutPinOe |-> trueOutPin != invertedOutPin)
		else $error("pins not complementary");
	a_stat_pair: assert property (regRead && regAddr == SRLU_OFS_STAT |=> regRdata[1] != regRdata[0])
		else $error("status halves not complementary");
	a_pulse_sets: assert property (s_pulse(2'h2) ##1 s_stat_rd |=> regRdata == 8'h01)
		else $error("pulse set missed");
	a_reset_wins: assert property (s_pulse(2'h3) ##1 s_stat_rd |=> regRdata == 8'h02)
		else $error("reset did not win");
	a_reset_clears_oe: assert property ($fell(reset) |-> !trueOutPinOe && !invertedOutPinOe)
		else $error("pin enable set after reset");
endmodule
bind srlu_top srlu_top_checker u_chk (.core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
	.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .trueOutPin(trueOutPin),
	.trueOutPinOe(trueOutPinOe), .invertedOutPin(invertedOutPin), .invertedOutPinOe(invertedOutPinOe));

// ---- verif/tb_srlu_top.sv ----
// Bench for the latch unit: pulses, routes, random sources, divider, reset.
// Assumes srlu_top, its checker and the source model are compiled first.
`timescale 1ns/10ps
module tb_srlu_top;
	import srlu_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdata;
	logic comp1, comp2, extPin, tPin, tOe, iPin, iOe;
	logic [2:0] want = 3'h0;
	logic [7:0] d;
	logic [7:0] s;
	logic q;
	logic [7:0] pv [10] = '{8'h82, 8'h81, 8'h82, 8'h83, 8'h02, 8'h8E, 8'h01, 8'h8D, 8'h89, 8'h85};
	int n_errors = 0;
	int checked = 0;
	int seed = 32'hfe1b;
	int n;
	int lo;
	srlu_top dut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .comparator1Output(comp1), .comparator2Output(comp2),
		.externalInterruptPin(extPin), .trueOutPin(tPin), .trueOutPinOe(tOe), .invertedOutPin(iPin),
		.invertedOutPinOe(iOe));
	srlu_src_model src (.core_clk(core_clk), .want(want), .comp1(comp1), .comp2(comp2), .pin(extPin));
	initial forever #5 core_clk = ~core_clk;
	// ----
	// Bus tasks and expectations
	// ----
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] v);
		@(posedge core_clk);
		regWrite <= w;
		regRead <= r;
		regAddr <= a;
		regWdata <= v;
	endtask
	task wr(input logic [1:0] a, input logic [7:0] v);
		bus(1'b1, 1'b0, a, v);
		bus(1'b0, 1'b0, a, v);
	endtask
	task rd(input logic [1:0] a);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1 d = regRdata;
	endtask
	task waitv(input logic v, output int k);
		k = 0;
		do begin
			@(posedge core_clk);
			#1 k++;
		end while (tPin !== v && k < 2000);
	endtask
	function automatic logic [7:0] stat(input logic v);
		return {6'h00, ~v, v};
	endfunction
	function automatic logic [7:0] pins(input logic [7:0] c, input logic v);
		return {4'h0, c[7] & c[3], c[7] & c[3] & v, c[7] & c[2], c[7] & c[2] & ~v};
	endfunction
	// Held levels: any enabled reset source wins, else any set source, else hold
	function automatic logic expq(input logic [7:0] e, input logic [2:0] v, input logic old);
		if ((e[3] & v[2]) | (e[1] & v[1]) | (e[0] & v[0])) return 1'b0;
		if ((e[7] & v[2]) | (e[5] & v[1]) | (e[4] & v[0])) return 1'b1;
		return old;
	endfunction
	task test_done;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#500000;
		n_errors++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		test_done;
	end
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		rd(SRLU_OFS_CTRL);
		chk(d, SRLU_CTRL_RESET);
		rd(SRLU_OFS_SRC);
		chk(d, SRLU_SRC_RESET);
		rd(2'h3);
		chk(d, 8'h00);
		$display("test reset values done");
		// Pins stay unrouted until a pulse has given the latch a known state; direction is outside
		for (int i = 0; i < 10; i++) begin
			wr(SRLU_OFS_CTRL, pv[i]);
			if (pv[i][7]) q = pv[i][0] ? 1'b0 : (pv[i][1] ? 1'b1 : q);
			rd(SRLU_OFS_STAT);
			chk(d, stat(q));
			rd(SRLU_OFS_CTRL);
			chk(d, pv[i] & 8'hFC);
			chk(pins(pv[i], q), {4'h0, tOe, tPin, iOe, iPin});
		end
		$display("test pulses and routes done");
		wr(SRLU_OFS_CTRL, 8'h82);
		q = 1'b1;
		for (int i = 0; i < 60; i++) begin
			s = (i == 0) ? 8'hBB : 8'($random(seed)) & 8'hBB;
			wr(SRLU_OFS_SRC, 8'h00);
			want <= (i == 0) ? 3'h7 : 3'($random(seed));
			repeat (4) @(posedge core_clk);
			wr(SRLU_OFS_SRC, s);
			repeat (4) @(posedge core_clk);
			q = expq(s, want, q);
			rd(SRLU_OFS_STAT);
			chk(d, stat(q));
		end
		$display("test random sources done");
		// Comparator 1 sets, divided clock resets: the true pin dips once per period
		want <= 3'h1;
		wr(SRLU_OFS_SRC, 8'h14);
		for (int c = 0; c < 8; c++) begin
			wr(SRLU_OFS_CTRL, {1'b1, 3'(c), 4'h8});
			waitv(1'b1, n);
			waitv(1'b0, n);
			waitv(1'b1, lo);
			waitv(1'b0, n);
			chk(16'(lo), 16'h0001);
			chk(16'(lo + n), 16'(4 << c));
		end
		$display("test divider done");
		wr(SRLU_OFS_SRC, 8'h00);
		wr(SRLU_OFS_CTRL, 8'h82);
		repeat (3) @(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rd(SRLU_OFS_STAT);
		chk(d, stat(1'b1));
		rd(SRLU_OFS_CTRL);
		chk(d, SRLU_CTRL_RESET);
		$display("test mid-run reset done");
		test_done;
	end
endmodule
